// ==== rtl/lpp_pkg.sv ====
// package of constants and carrier types for the page program sequencer
package lpp_pkg;

	localparam int          COL_W         = 12;
	localparam int          ROW_W         = 16;
	localparam int          PLANE_W       = 1;
	localparam int          DATA_W        = 16;
	localparam logic [7:0]  CMD_PROG_EXEC = 8'h10;
	localparam logic [7:0]  CMD_INTERLEAVE = 8'h11;
	localparam logic [7:0]  CMD_CACHE_PROG = 8'h15;
	localparam logic [7:0]  CMD_NONE      = 8'h00;
	localparam logic [7:0]  STATUS_RESET  = 8'hE0;
	localparam int          STS_RDY       = 6;
	localparam int          STS_ARDY      = 5;
	localparam int          STS_CSP       = 1;
	localparam int          PLANE_LSB     = 0;

	// address delivered by the target in one beat
	typedef struct packed {
		logic [ROW_W-1:0] row;
		logic [COL_W-1:0] col;
	} lpp_addr_type;

	// one data beat for the page register
	typedef struct packed {
		logic [COL_W-1:0]  col;
		logic [DATA_W-1:0] data;
		logic              wide;
	} lpp_beat_type;

	typedef enum logic [9:0] {
		ST_IDLE    = 10'h001,
		ST_ENTRY   = 10'h002,
		ST_ADDR    = 10'h004,
		ST_WAIT    = 10'h008,
		ST_ACCEPT  = 10'h010,
		ST_PROG    = 10'h020,
		ST_CACHE   = 10'h040,
		ST_MPL     = 10'h080,
		ST_COLSEL  = 10'h100,
		ST_ROWSEL  = 10'h200
	} lpp_state_type;

endpackage

// ==== rtl/lpp_fifo.sv ====
// small valid/ready FIFO carrying data beats toward the page register
`timescale 1ns/10ps
module lpp_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	// clock and reset
	input  wire logic             core_clk,
	input  wire logic             nrst,
	// fill side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ff, nxt_wr, rd_ff, nxt_rd;
	logic [AW:0]      cnt_ff, nxt_cnt;
	logic             push, pop;

	assign in_ready  = (cnt_ff != (AW+1)'(DEPTH));
	assign out_valid = (cnt_ff != '0);
	assign out_data  = mem[rd_ff];

	always_comb begin
		push    = in_valid && in_ready;
		pop     = out_valid && out_ready;
		nxt_wr  = push ? ((wr_ff == AW'(DEPTH-1)) ? '0 : wr_ff + 1'b1) : wr_ff;
		nxt_rd  = pop ? ((rd_ff == AW'(DEPTH-1)) ? '0 : rd_ff + 1'b1) : rd_ff;
		nxt_cnt = cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			wr_ff  <= '0;
			rd_ff  <= '0;
			cnt_ff <= '0;
		end else begin
			wr_ff  <= nxt_wr;
			rd_ff  <= nxt_rd;
			cnt_ff <= nxt_cnt;
		end
	end

	// storage has no reset; only the pointers and the count need a defined value
	always_ff @(posedge core_clk) begin
		if (push) begin
			mem[wr_ff] <= in_data;
		end
	end

endmodule // lpp_fifo

// ==== rtl/lpp_seq.sv ====
// page program sequencer of one logical unit
`timescale 1ns/10ps
// Summary of operation
// - entry clears interleave flag, then goes to address handling unconditionally
// - address state first stores the full address from the target
// - with multi-plane support, plane field picks the target page register
// - column from address sets write position, then go to data wait
// - data wait idles for input and records itself as resume state
// - target passes one data unit; unit moves to data accept
// - accept stores byte or word at column, advances column, back to wait
// - confirm 10h to program, 15h to cache, 11h to multi-plane
// - column reselect request in data wait goes to column reselect
// - row reselect request in data wait goes to row reselect
// - program entry clears status bits 6 and 5 and reports bit 6
// - program state records 10h as last confirm command
// - single page program clears the interleave flag
// - program starts array write; with interleave set and no single page request, all queued pages
// - without caching or overlap support, status bit 1 updates are ignored
// - requested page done with interleave clear leads to program status
// - cache program entry records 15h as last confirm command
module lpp_seq
	import lpp_pkg::*;
#(
	parameter bit MULTI_PLANE = 1'b1,
	parameter bit INTERLEAVE  = 1'b1,
	parameter bit CACHE_SUP   = 1'b1,
	parameter int FIFO_DEPTH  = 8
) (
	// clock and reset
	input  wire logic                  core_clk,
	input  wire logic                  nrst,
	// configuration
	input  wire logic                  bus_wide,
	// requests from target logic
	input  wire logic                  prog_start,
	input  wire logic                  addr_valid,
	input  wire lpp_pkg::lpp_addr_type addr_in,
	input  wire logic                  data_valid,
	output logic                       data_ready,
	input  wire logic [DATA_W-1:0]     data_in,
	input  wire logic                  cmd_valid,
	input  wire logic [7:0]            cmd_code,
	input  wire logic                  col_sel_req,
	input  wire logic                  row_sel_req,
	input  wire logic                  single_page,
	input  wire logic                  page_done,
	input  wire logic                  sts_bit1_set,
	// page register write port
	output logic                       pr_we,
	output logic [PLANE_W-1:0]         pr_plane,
	output lpp_pkg::lpp_beat_type      pr_beat,
	input  wire logic                  pr_ready,
	// status and bookkeeping
	output logic [7:0]                 unit_status_bits,
	output logic                       status_rdy,
	output logic [7:0]                 last_confirm_cmd,
	output logic                       interleave_flag,
	output lpp_pkg::lpp_state_type     resume_state,
	output lpp_pkg::lpp_state_type     state,
	output lpp_pkg::lpp_addr_type      stored_addr,
	output logic                       array_prog,
	output logic                       prog_all,
	output logic                       to_prog_status
);
	import lpp_pkg::*;

	// ----------------------------------------------------------------
	// state and bookkeeping
	// ----------------------------------------------------------------
	lpp_state_type     st_ff, nxt_st, rs_ff, nxt_rs;
	lpp_addr_type      adr_ff, nxt_adr;
	logic [COL_W-1:0]  col_ff, nxt_col;
	logic [PLANE_W-1:0] pl_ff, nxt_pl;
	logic [7:0]        sts_ff, nxt_sts, lc_ff, nxt_lc;
	logic              il_ff, nxt_il, rdy_ff, nxt_rdy;
	logic              ap_ff, nxt_ap, pa_ff, nxt_pa, ps_ff, nxt_ps, wp_ff, nxt_wp;
	logic              fifo_in_ready, fifo_out_valid;
	lpp_beat_type      beat_ff, nxt_beat, fifo_out;
	logic              acc_push_ff, nxt_acc_push;
	localparam int     OCC_W = $clog2(FIFO_DEPTH) + 1;
	logic [OCC_W-1:0]  occ_ff, nxt_occ;
	logic [DATA_W-1:0] dat_ff, nxt_dat;
	logic              take, drain;

	function automatic logic [COL_W-1:0] col_step(input logic [COL_W-1:0] c, input logic w);
		col_step = c + (w ? COL_W'(2) : COL_W'(1));
	endfunction

	// a credit is held from take until the page register drains the beat; the FIFO only
	// counts a beat three cycles after take, so its own room flag alone would overfill it
	assign data_ready = (st_ff == ST_WAIT) && fifo_in_ready && (occ_ff != OCC_W'(FIFO_DEPTH));
	assign take       = (st_ff == ST_WAIT) && data_valid && data_ready;
	assign drain      = fifo_out_valid && pr_ready;

	always_comb begin
		nxt_st       = st_ff;
		nxt_rs       = rs_ff;
		nxt_adr      = adr_ff;
		nxt_col      = col_ff;
		nxt_pl       = pl_ff;
		nxt_sts      = sts_ff;
		nxt_lc       = lc_ff;
		nxt_il       = il_ff;
		nxt_rdy      = rdy_ff;
		nxt_ap       = 1'b0;
		nxt_pa       = pa_ff;
		nxt_ps       = 1'b0;
		nxt_beat     = beat_ff;
		nxt_acc_push = 1'b0;
		nxt_dat      = dat_ff;
		nxt_occ      = occ_ff + OCC_W'(take) - OCC_W'(drain);
		unique case (st_ff)
			ST_IDLE: begin
				if (prog_start) begin
					nxt_st = ST_ENTRY;
				end
			end
			ST_ENTRY: begin
				nxt_il = 1'b0;
				nxt_st = ST_ADDR;
			end
			ST_ADDR: begin
				// hold here until the target presents the address; nothing is selected before it
				if (addr_valid) begin
					nxt_adr = addr_in;
					nxt_pl  = MULTI_PLANE ? addr_in.row[PLANE_LSB +: PLANE_W] : '0;
					nxt_col = addr_in.col;
					nxt_st  = ST_WAIT;
				end
			end
			ST_WAIT: begin
				nxt_rs = ST_WAIT;
				if (take) begin
					nxt_dat = data_in;
					nxt_st  = ST_ACCEPT;
				end else if (cmd_valid && cmd_code == CMD_PROG_EXEC) begin
					nxt_st = ST_PROG;
				end else if (cmd_valid && cmd_code == CMD_CACHE_PROG) begin
					nxt_st = ST_CACHE;
				end else if (cmd_valid && cmd_code == CMD_INTERLEAVE) begin
					nxt_st = ST_MPL;
				end else if (col_sel_req) begin
					nxt_st = ST_COLSEL;
				end else if (row_sel_req) begin
					nxt_st = ST_ROWSEL;
				end
			end
			ST_ACCEPT: begin
				nxt_beat.col  = col_ff;
				nxt_beat.data = bus_wide ? dat_ff : {{(DATA_W-8){1'b0}}, dat_ff[7:0]};
				nxt_beat.wide = bus_wide;
				nxt_acc_push  = 1'b1;
				nxt_col       = col_step(col_ff, bus_wide);
				nxt_st        = ST_WAIT;
			end
			ST_PROG: begin
				nxt_sts[STS_RDY]  = 1'b0;
				nxt_sts[STS_ARDY] = 1'b0;
				nxt_rdy           = 1'b0;
				nxt_lc            = CMD_PROG_EXEC;
				if (single_page || !INTERLEAVE) begin
					nxt_il = 1'b0;
				end
				nxt_ap = 1'b1;
				nxt_pa = INTERLEAVE && !single_page && il_ff;
				nxt_st = ST_IDLE;
			end
			ST_CACHE: begin
				nxt_sts[STS_RDY]  = 1'b0;
				nxt_sts[STS_ARDY] = 1'b0;
				nxt_rdy           = 1'b0;
				nxt_lc            = CMD_CACHE_PROG;
				nxt_st            = ST_IDLE;
			end
			ST_MPL: begin
				nxt_il = INTERLEAVE;
				nxt_st = ST_IDLE;
			end
			ST_COLSEL, ST_ROWSEL: begin
				nxt_st = ST_IDLE;
			end
			default: begin
				nxt_st = ST_IDLE;
			end
		endcase
		// program wait: page done with interleave clear hands over to status
		if (wp_ff && page_done && !nxt_il) begin
			nxt_ps = 1'b1;
		end
		if (sts_bit1_set && (CACHE_SUP || INTERLEAVE)) begin
			nxt_sts[STS_CSP] = 1'b1;
		end
	end

	always_comb begin
		nxt_wp = wp_ff;
		if (ap_ff) begin
			nxt_wp = 1'b1;
		end else if (wp_ff && page_done) begin
			nxt_wp = 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			st_ff       <= ST_IDLE;
			rs_ff       <= ST_IDLE;
			adr_ff      <= '0;
			col_ff      <= '0;
			pl_ff       <= '0;
			sts_ff      <= STATUS_RESET;
			lc_ff       <= CMD_NONE;
			il_ff       <= 1'b0;
			rdy_ff      <= 1'b1;
			ap_ff       <= 1'b0;
			pa_ff       <= 1'b0;
			ps_ff       <= 1'b0;
			wp_ff       <= 1'b0;
			beat_ff     <= '0;
			acc_push_ff <= 1'b0;
			occ_ff      <= '0;
			dat_ff      <= '0;
		end else begin
			st_ff       <= nxt_st;
			rs_ff       <= nxt_rs;
			adr_ff      <= nxt_adr;
			col_ff      <= nxt_col;
			pl_ff       <= nxt_pl;
			sts_ff      <= nxt_sts;
			lc_ff       <= nxt_lc;
			il_ff       <= nxt_il;
			rdy_ff      <= nxt_rdy;
			ap_ff       <= nxt_ap;
			pa_ff       <= nxt_pa;
			ps_ff       <= nxt_ps;
			wp_ff       <= nxt_wp;
			beat_ff     <= nxt_beat;
			acc_push_ff <= nxt_acc_push;
			occ_ff      <= nxt_occ;
			dat_ff      <= nxt_dat;
		end
	end

	// ----------------------------------------------------------------
	// data path to the page register
	// ----------------------------------------------------------------
	// the beat is pushed one cycle after accept; data_ready already gated on room
	lpp_fifo #(
		.WIDTH ($bits(lpp_beat_type)),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.core_clk  (core_clk),
		.nrst      (nrst),
		.in_valid  (acc_push_ff),
		.in_ready  (fifo_in_ready),
		.in_data   (beat_ff),
		.out_valid (fifo_out_valid),
		.out_ready (pr_ready),
		.out_data  (fifo_out)
	);

	logic         we_ff;
	lpp_beat_type pb_ff;
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			we_ff <= 1'b0;
			pb_ff <= '0;
		end else begin
			we_ff <= fifo_out_valid && pr_ready;
			pb_ff <= fifo_out;
		end
	end

	assign pr_we            = we_ff;
	assign pr_beat          = pb_ff;
	assign pr_plane         = pl_ff;
	assign unit_status_bits = sts_ff;
	assign status_rdy       = rdy_ff;
	assign last_confirm_cmd = lc_ff;
	assign interleave_flag  = il_ff;
	assign resume_state     = rs_ff;
	assign state            = st_ff;
	assign stored_addr      = adr_ff;
	assign array_prog       = ap_ff;
	assign prog_all         = pa_ff;
	assign to_prog_status   = ps_ff;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	sequence s_accept;
		st_ff == ST_WAIT && data_valid && data_ready;
	endsequence

	sequence s_start;
		st_ff == ST_IDLE && prog_start;
	endsequence

	sequence s_enter;
		st_ff == ST_ENTRY ##1 st_ff == ST_ADDR;
	endsequence

	a_start_flow: assert property (@(posedge core_clk) disable iff (!nrst)
		s_start |=> s_enter) else $error("entry did not pass to address handling");
	a_entry_to_addr: assert property (@(posedge core_clk) disable iff (!nrst)
		st_ff == ST_ENTRY |=> !il_ff && st_ff == ST_ADDR) else $error("interleave flag not cleared on entry");
	a_addr_store: assert property (@(posedge core_clk) disable iff (!nrst)
		st_ff == ST_ADDR && addr_valid |=> adr_ff == $past(addr_in) && st_ff == ST_WAIT)
		else $error("address not stored");
	a_plane_pick: assert property (@(posedge core_clk) disable iff (!nrst)
		st_ff == ST_ADDR && addr_valid |=> !MULTI_PLANE || pl_ff == adr_ff.row[PLANE_LSB +: PLANE_W])
		else $error("page register not picked from plane field");
	a_col_set: assert property (@(posedge core_clk) disable iff (!nrst)
		st_ff == ST_ADDR && addr_valid |=> col_ff == $past(addr_in.col)) else $error("column not set");
	a_resume_wait: assert property (@(posedge core_clk) disable iff (!nrst)
		st_ff == ST_WAIT |=> rs_ff == ST_WAIT) else $error("resume state not recorded");
	a_data_accept: assert property (@(posedge core_clk) disable iff (!nrst)
		s_accept |=> st_ff == ST_ACCEPT ##1 st_ff == ST_WAIT) else $error("accept sequence broken");
	a_col_step: assert property (@(posedge core_clk) disable iff (!nrst)
		st_ff == ST_ACCEPT |=> col_ff == col_step($past(col_ff), $past(bus_wide))) else $error("column step wrong");
	a_prog_cmd: assert property (@(posedge core_clk) disable iff (!nrst)
		st_ff == ST_WAIT && !data_valid && cmd_valid && cmd_code == CMD_PROG_EXEC |=> st_ff == ST_PROG)
		else $error("program confirm not taken");
	a_prog_status: assert property (@(posedge core_clk) disable iff (!nrst)
		st_ff == ST_PROG |=> !sts_ff[STS_RDY] && !sts_ff[STS_ARDY] && !rdy_ff) else $error("status not cleared");
	a_prog_confirm: assert property (@(posedge core_clk) disable iff (!nrst)
		st_ff == ST_PROG |=> lc_ff == CMD_PROG_EXEC && ap_ff) else $error("program bookkeeping wrong");
	a_cache_confirm: assert property (@(posedge core_clk) disable iff (!nrst)
		st_ff == ST_CACHE |=> lc_ff == CMD_CACHE_PROG) else $error("cache confirm not recorded");
	a_cache_cmd: assert property (@(posedge core_clk) disable iff (!nrst)
		st_ff == ST_WAIT && !data_valid && cmd_valid && cmd_code == CMD_CACHE_PROG |=> st_ff == ST_CACHE)
		else $error("cache confirm not taken");
	a_mpl_cmd: assert property (@(posedge core_clk) disable iff (!nrst)
		st_ff == ST_WAIT && !data_valid && cmd_valid && cmd_code == CMD_INTERLEAVE |=> st_ff == ST_MPL)
		else $error("interleave confirm not taken");
	a_col_req: assert property (@(posedge core_clk) disable iff (!nrst)
		st_ff == ST_WAIT && !data_valid && !cmd_valid && col_sel_req |=> st_ff == ST_COLSEL)
		else $error("column reselect not taken");
	a_row_req: assert property (@(posedge core_clk) disable iff (!nrst)
		st_ff == ST_WAIT && !data_valid && !cmd_valid && !col_sel_req && row_sel_req |=> st_ff == ST_ROWSEL)
		else $error("row reselect not taken");
	a_single_page: assert property (@(posedge core_clk) disable iff (!nrst)
		st_ff == ST_PROG && single_page |=> !il_ff && !pa_ff) else $error("single page kept interleave");
	a_bit1_set: assert property (@(posedge core_clk) disable iff (!nrst)
		sts_bit1_set && (CACHE_SUP || INTERLEAVE) |=> sts_ff[STS_CSP]) else $error("status bit 1 not set");
	a_status_hand: assert property (@(posedge core_clk) disable iff (!nrst)
		wp_ff && page_done && !il_ff && st_ff == ST_IDLE |=> ps_ff) else $error("program status not reached");
	a_no_overflow: assert property (@(posedge core_clk) disable iff (!nrst)
		acc_push_ff |-> fifo_in_ready) else $error("accepted beat pushed into a full buffer");

endmodule // lpp_seq

// ==== bench/lpp_target_model.sv ====
// target-side model relaying host requests into the sequencer
`timescale 1ns/10ps
module lpp_target_model
	import lpp_pkg::*;
(
	// clock and sequencer view
	input  wire logic                   core_clk,
	input  wire lpp_pkg::lpp_state_type state,
	input  wire logic                   data_ready,
	// requests toward the unit
	output logic                        prog_start,
	output logic                        addr_valid,
	output lpp_pkg::lpp_addr_type       addr_in,
	output logic                        data_valid,
	output logic [DATA_W-1:0]           data_in,
	output logic                        cmd_valid,
	output logic [7:0]                  cmd_code,
	output logic                        col_sel_req,
	output logic                        row_sel_req
);
	initial begin
		{prog_start, addr_valid, data_valid, cmd_valid, col_sel_req, row_sel_req} = 6'h00;
		addr_in = '0;
		data_in = 16'h0000;
		cmd_code = 8'h00;
	end
	task automatic step();
		@(posedge core_clk);
		#10;
	endtask
	task automatic start_seq(input lpp_addr_type a);
		prog_start = 1'b1;
		for (int i = 0; i < 8 && state !== ST_ENTRY; i++) step();
		prog_start = 1'b0;
		addr_valid = 1'b1;
		addr_in = a;
		for (int i = 0; i < 8 && state !== ST_WAIT; i++) step();
		addr_valid = 1'b0;
		// released lines must not keep the last value
		addr_in = ~a;
	endtask
	task automatic send_beat(input logic [DATA_W-1:0] d, output bit ok);
		for (int i = 0; i < 4 && !(state === ST_WAIT && data_ready === 1'b1); i++) step();
		ok = (state === ST_WAIT && data_ready === 1'b1);
		if (ok) begin
			data_valid = 1'b1;
			data_in = d;
			step();
			data_valid = 1'b0;
			data_in = ~d;
		end
	endtask
	task automatic send_op(input int kind, input logic [7:0] code);
		for (int i = 0; i < 4 && state !== ST_WAIT; i++) step();
		cmd_code = code;
		cmd_valid = (kind == 0);
		col_sel_req = (kind == 1);
		row_sel_req = (kind == 2);
		step();
		{cmd_valid, col_sel_req, row_sel_req} = 3'h0;
		cmd_code = ~code;
	endtask
endmodule // lpp_target_model

// ==== bench/tb.sv ====
// self-checking bench for the page program sequencer
`timescale 1ns/10ps
module tb;
	import lpp_pkg::*;
	logic                  core_clk, nrst, bus_wide, single_page, page_done, pr_ready, sts_bit1_set;
	logic                  prog_start, addr_valid, data_valid, data_ready, cmd_valid, col_sel_req, row_sel_req;
	logic [DATA_W-1:0]     data_in;
	logic [7:0]            cmd_code, unit_status_bits, last_confirm_cmd;
	logic                  pr_we, status_rdy, interleave_flag, array_prog, prog_all, to_prog_status;
	logic [PLANE_W-1:0]    pr_plane;
	lpp_beat_type          pr_beat;
	lpp_state_type         resume_state, state;
	lpp_addr_type          addr_in, stored_addr, a;
	lpp_beat_type          beats[$];
	logic                  planes[$];
	lpp_state_type         exits[3] = '{ST_MPL, ST_COLSEL, ST_ROWSEL};
	int                    error_cnt = 0, check_count = 0, cyc_cnt = 0, ap_cnt = 0, tps_cnt = 0, n;
	bit                    ok;

	lpp_seq #(.MULTI_PLANE(1'b1), .INTERLEAVE(1'b1), .CACHE_SUP(1'b1), .FIFO_DEPTH(8)) dut_u (
		.core_clk(core_clk), .nrst(nrst), .bus_wide(bus_wide), .prog_start(prog_start),
		.addr_valid(addr_valid), .addr_in(addr_in), .data_valid(data_valid), .data_ready(data_ready),
		.data_in(data_in), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .col_sel_req(col_sel_req),
		.row_sel_req(row_sel_req), .single_page(single_page), .page_done(page_done), .sts_bit1_set(sts_bit1_set),
		.pr_we(pr_we), .pr_plane(pr_plane), .pr_beat(pr_beat), .pr_ready(pr_ready),
		.unit_status_bits(unit_status_bits), .status_rdy(status_rdy), .last_confirm_cmd(last_confirm_cmd),
		.interleave_flag(interleave_flag), .resume_state(resume_state), .state(state),
		.stored_addr(stored_addr), .array_prog(array_prog), .prog_all(prog_all),
		.to_prog_status(to_prog_status));

	lpp_target_model tgt_u (
		.core_clk(core_clk), .state(state), .data_ready(data_ready), .prog_start(prog_start),
		.addr_valid(addr_valid), .addr_in(addr_in), .data_valid(data_valid), .data_in(data_in),
		.cmd_valid(cmd_valid), .cmd_code(cmd_code), .col_sel_req(col_sel_req), .row_sel_req(row_sel_req));

	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end

	// ----------------------------------------
	// monitors and hang guard
	// ----------------------------------------
	// outputs are sampled mid-cycle, where they have settled after the launching edge
	always @(negedge core_clk) begin
		cyc_cnt++;
		if (cyc_cnt == 5000) begin
			error_cnt++;
			end_sim();
		end
		if (pr_we === 1'b1) begin
			beats.push_back(pr_beat);
			planes.push_back(pr_plane[0]);
		end
		if (array_prog === 1'b1) ap_cnt++;
		if (to_prog_status === 1'b1) tps_cnt++;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t %s", $time, msg);
		end
	endtask
	task automatic wt(input int c);
		repeat (c) @(posedge core_clk);
		#10;
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		nrst = 1'b0;
		bus_wide = 1'b1;
		single_page = 1'b1;
		page_done = 1'b0;
		pr_ready = 1'b0;
		sts_bit1_set = 1'b0;
		wt(4);
		nrst = 1'b1;
		wt(1);
		chk(unit_status_bits, STATUS_RESET, "status reset");
		chk(last_confirm_cmd, CMD_NONE, "confirm reset");
		chk(state, ST_IDLE, "idle after reset");
		chk(unit_status_bits[STS_CSP], 1'b0, "bit 1 clear after reset");
		sts_bit1_set = 1'b1;
		wt(1);
		sts_bit1_set = 1'b0;
		chk(unit_status_bits[STS_CSP], 1'b1, "bit 1 set with caching supported");
		// x16 beats into a stalled page register until the buffer refuses
		a = '{row: 16'h0003, col: 12'h010};
		tgt_u.start_seq(a);
		chk(stored_addr, a, "address stored");
		n = 0;
		ok = 1'b1;
		while (ok && n < 12) begin
			tgt_u.send_beat(16'hA000 + 16'(n), ok);
			if (ok) n++;
		end
		chk(resume_state, ST_WAIT, "resume state");
		chk(n, 8, "buffer refusal point");
		pr_ready = 1'b1;
		wt(30);
		chk(beats.size(), n, "all beats drained");
		foreach (beats[i]) begin
			chk(beats[i], {12'h010 + 12'(2 * i), 16'hA000 + 16'(i), 1'b1}, "x16 beat");
			chk(planes[i], 1'b1, "plane from row");
		end
		beats.delete();
		planes.delete();
		tgt_u.send_op(0, CMD_PROG_EXEC);
		wt(3);
		chk(ap_cnt, 1, "array program started");
		chk(prog_all, 1'b0, "single page only");
		chk(last_confirm_cmd, CMD_PROG_EXEC, "confirm 10h recorded");
		chk(unit_status_bits[6:5], 2'h0, "busy bits cleared");
		chk(status_rdy, 1'b0, "busy reported");
		chk(interleave_flag, 1'b0, "flag clear");
		page_done = 1'b1;
		wt(1);
		page_done = 1'b0;
		wt(2);
		chk(tps_cnt, 1, "program status reached");
		// x8 bytes ending in a cache confirm
		bus_wide = 1'b0;
		a = '{row: 16'h0002, col: 12'h0FF};
		tgt_u.start_seq(a);
		tgt_u.send_beat(16'h55AB, ok);
		tgt_u.send_beat(16'h55CD, ok);
		tgt_u.send_op(0, CMD_CACHE_PROG);
		chk(state, ST_CACHE, "cache confirm");
		wt(6);
		chk(last_confirm_cmd, CMD_CACHE_PROG, "confirm 15h recorded");
		chk(beats.size(), 2, "two bytes");
		chk({beats[0].col, beats[0].data, beats[0].wide, planes[0]}, {12'h0FF, 16'h00AB, 2'h0}, "byte 0");
		chk({beats[1].col, beats[1].data, beats[1].wide}, {12'h100, 16'h00CD, 1'b0}, "byte 1");
		// remaining exits of data wait, each after a fresh entry
		for (int k = 0; k < 3; k++) begin
			tgt_u.start_seq(a);
			chk(interleave_flag, 1'b0, "entry clears flag");
			tgt_u.send_op(k, CMD_INTERLEAVE);
			chk(state, exits[k], "data wait exit");
			wt(2);
			if (k == 0) chk(interleave_flag, 1'b1, "interleave flag set");
		end
		end_sim();
	end
endmodule // tb
